// [verification/rgt_fb_model.sv]
// Frame buffer partner: answers each read pulse with the addressed byte.
// Assumes the length byte sits at address 0; data is garbage outside its hold time.
module rgt_fb_model #(
  parameter logic [7:0] LEN = 8'h01
) (
  input  wire logic       ref_clk,
  input  wire logic       fb_rd,
  input  wire logic [6:0] fb_addr,
  output logic      [7:0] fb_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem_q [128]; // Buffer contents
  logic       hold_q;      // Second valid cycle after a read

  // Contents: length first, then a simple pattern
  initial begin
    fb_data = 8'h00;
    hold_q = 1'b0;
    for (int i = 0; i < 128; i++) mem_q[i] = 8'h5A ^ 8'(i);
    mem_q[0] = LEN;
  end

  // Read answer held two cycles, then inverted each cycle so stale data never passes
  always @(posedge ref_clk) begin
    if (fb_rd) begin
      fb_data <= mem_q[fb_addr];
      hold_q <= 1'b1;
    end else if (hold_q) hold_q <= 1'b0;
    else fb_data <= ~fb_data;
  end
endmodule

// [verification/rgt_props.sv]
// Concurrent checks on the ports of the receive gating, gain and transmit-start block.
// Assumes it is bound to the top module and sees only its ports; one clock domain.
module rgt_props (
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       reg_re,
  input wire logic [7:0] reg_rdata,
  input wire logic       shr_detect,
  input wire logic       demod_start,
  input wire logic       rx_busy,
  input wire logic [1:0] gain_level,
  input wire logic       gain_held,
  input wire logic       fb_rd,
  input wire logic       tx_chip_strobe,
  input wire logic       tx_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Cycles since transmit went busy, frozen at the first chip
  logic [11:0] lead_q;
  logic        seen_q;

  // Lead counter: cleared whenever idle so each frame is timed afresh
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !tx_busy) begin
      lead_q <= 12'h000;
      seen_q <= 1'b0;
    end else if (!seen_q) begin
      lead_q <= lead_q + 12'h001;
      seen_q <= tx_chip_strobe;
    end
  end

  // Chips are spaced well apart, never in adjacent cycles
  sequence s_chip_gap;
    (!tx_chip_strobe) [*8];
  endsequence

  // Demodulation start is one pulse followed by the busy level
  sequence s_accept;
    !demod_start && rx_busy;
  endsequence

  a_rdata_idle_zero: assert property (!$past(reg_re) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_demod_one_pulse: assert property (demod_start |=> s_accept)
    else $error("frame accept not followed by receive busy");
  a_demod_has_cause: assert property (demod_start |-> $past(shr_detect))
    else $error("demodulation started without a frame start");
  a_gain_not_rsv: assert property (gain_level != rgt_pkg::GAIN_RSV)
    else $error("gain level took the reserved code");
  a_held_keeps_gain: assert property (gain_held && $past(gain_held) |-> $stable(gain_level))
    else $error("gain moved while frozen");
  a_chip_spacing: assert property (tx_chip_strobe |=> s_chip_gap)
    else $error("chip strobes too close");
  a_chip_in_busy: assert property (tx_chip_strobe |-> tx_busy && !rx_busy)
    else $error("chip sent outside transmit");
  a_lead_time: assert property (tx_chip_strobe && !seen_q |-> lead_q inside {[12'h7D0:12'h816]})
    else $error("first chip not about sixteen microseconds after start");
  a_fb_rd_pulse: assert property (fb_rd |=> !fb_rd && tx_busy)
    else $error("frame buffer read not a single pulse in transmit");
  c_accept: cover property (demod_start);
endmodule

// [verification/rgt_rx_gating_gain_tx_start_tb.sv]
// Self-checking bench: registers, receive gating, gain overrides, transmit start.
// Assumes the frame buffer partner holds a one-byte frame.
module rgt_rx_gating_gain_tx_start_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, sys_rst = 1'b1, reg_we = 1'b0, reg_re = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00, frame_strength = 8'h00, reg_rdata, fb_data;
  logic shr_detect = 1'b0, rx_frame_done = 1'b0, sleep_tx_trigger_pin = 1'b0;
  logic [1:0] auto_gain = 2'h0, gain_level;
  logic demod_start, rx_busy, gain_held, fb_rd, tx_chip, tx_chip_strobe, tx_busy;
  logic [6:0] fb_addr;
  int fails = 0, total_checks = 0;
  logic [7:0] v, str;
  logic [3:0] thr;
  logic blk;
  logic [5:0] ra [3] = '{rgt_pkg::OFS_RX_SYNC, rgt_pkg::OFS_GAIN_TEST, rgt_pkg::OFS_TRX_CTRL0};
  logic [7:0] rm [3] = '{rgt_pkg::RXS_MASK, rgt_pkg::GT_MASK, rgt_pkg::TC0_MASK};

  rgt_rx_gating_gain_tx_start u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .sleep_tx_trigger_pin(sleep_tx_trigger_pin),
    .shr_detect(shr_detect), .frame_strength(frame_strength), .rx_frame_done(rx_frame_done),
    .auto_gain(auto_gain), .fb_data(fb_data), .demod_start(demod_start), .rx_busy(rx_busy),
    .gain_level(gain_level), .gain_held(gain_held), .fb_addr(fb_addr), .fb_rd(fb_rd),
    .tx_chip(tx_chip), .tx_chip_strobe(tx_chip_strobe), .tx_busy(tx_busy));
  rgt_fb_model #(.LEN(8'h01)) u_fb (.ref_clk(ref_clk), .fb_rd(fb_rd), .fb_addr(fb_addr),
    .fb_data(fb_data));

  // 125 MHz clock
  initial forever #4 ref_clk = ~ref_clk;

  // Summary, verdict and end of run
  task automatic complete_run;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Compare one result; four-state so unknowns fail
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write, a gap cycle so strobes are never reassigned in one step
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge ref_clk);
    reg_we <= 1'b0;
    @(posedge ref_clk);
  endtask

  // One-cycle read; data looked at only in the answer cycle
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge ref_clk);
    reg_re <= 1'b0;
    #1 chk("reg_rdata", exp, reg_rdata);
    @(posedge ref_clk);
  endtask

  // Acceptance as the threshold formula gives it, in dB above the floor
  function automatic logic acc(logic b, logic [3:0] t, logic [7:0] s);
    return !b && (t == 4'h0 || int'(s) > 3 * (int'(t) - 1));
  endfunction

  // End-of-frame pulse
  task automatic fin;
    rx_frame_done <= 1'b1;
    @(posedge ref_clk);
    rx_frame_done <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Frame start with a strength, then the end of frame
  task automatic frame(input logic [7:0] s, input logic e);
    shr_detect <= 1'b1;
    frame_strength <= s;
    @(posedge ref_clk);
    shr_detect <= 1'b0;
    #1 chk("demod_start", e, demod_start);
    @(posedge ref_clk);
    fin();
  endtask

  // Poll gain under a bound, then compare
  task automatic gchk(input logic [1:0] e);
    #1;
    for (int i = 0; i < 8 && gain_level !== e; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("gain_level", e, gain_level);
    @(posedge ref_clk);
  endtask

  // Follow one transmission, collect symbol-zero chips and buffer reads
  task automatic txrun(input logic [4:0] home);
    int n, r;
    logic [31:0] sh;
    logic ok;
    logic [6:0] fa;
    n = 0;
    fa = 7'h7F;
    r = 0;
    sh = 32'h0;
    ok = 1'b0;
    for (int c = 0; c < 40000 && !ok; c++) begin
      @(posedge ref_clk);
      #1;
      if (c == 1) chk("tx_busy", 1, tx_busy);
      if (tx_chip_strobe === 1'b1 && n < 32) sh[n] = tx_chip;
      n += int'(tx_chip_strobe === 1'b1);
      r += int'(fb_rd === 1'b1);
      if (fb_rd === 1'b1) fa = fb_addr;
      ok = c > 1 && tx_busy !== 1'b1;
    end
    if (!ok) begin
      fails++;
      complete_run();
    end
    chk("chips", 448, n);
    chk("symbol0", rgt_pkg::CHIP_SEQ0, sh);
    chk("fb_reads", 2, r);
    chk("fb_addr", 8'h01, fa);
    @(posedge ref_clk);
    sleep_tx_trigger_pin <= 1'b0;
    rd(rgt_pkg::OFS_STATE_CTRL, {3'h0, home});
  endtask

  initial begin
    void'($urandom(32'hD9FF));
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    // Reset values, reserved bits and random write-back
    for (int k = 0; k < 3; k++) begin
      rd(ra[k], 8'h00);
      wr(ra[k], 8'hFF);
      rd(ra[k], rm[k]);
      v = 8'($urandom);
      wr(ra[k], v);
      rd(ra[k], v & rm[k]);
      wr(ra[k], 8'h00);
    end
    wr(6'h10, 8'hFF);
    rd(6'h10, 8'h00);
    rd(rgt_pkg::OFS_STATE_CTRL, {3'h0, rgt_pkg::CMD_TRX_OFF});
    // Receive gating: corners, then random threshold and block mixes
    wr(rgt_pkg::OFS_STATE_CTRL, {3'h0, rgt_pkg::CMD_RX_ON});
    rd(rgt_pkg::OFS_STATE_CTRL, {3'h0, rgt_pkg::CMD_RX_ON});
    frame(8'h00, 1'b1);
    wr(rgt_pkg::OFS_RX_SYNC, 8'h0F);
    frame(8'h2A, 1'b0);
    frame(8'h2B, 1'b1);
    for (int i = 0; i < 16; i++) begin
      blk = ($urandom % 4) == 0;
      thr = 4'($urandom % 16);
      str = (thr == 4'h0) ? 8'($urandom) : 8'(3 * (thr - 1) + $urandom % 3);
      wr(rgt_pkg::OFS_RX_SYNC, {blk, 3'h0, thr});
      frame(str, acc(blk, thr, str));
    end
    // Block set during a reception leaves it running
    wr(rgt_pkg::OFS_RX_SYNC, 8'h00);
    shr_detect <= 1'b1;
    frame_strength <= 8'h10;
    @(posedge ref_clk);
    shr_detect <= 1'b0;
    wr(rgt_pkg::OFS_RX_SYNC, 8'h80);
    rd(rgt_pkg::OFS_STATE_CTRL, {3'h0, rgt_pkg::CODE_RX_BUSY});
    fin();
    rd(rgt_pkg::OFS_STATE_CTRL, {3'h0, rgt_pkg::CMD_RX_ON});
    frame(8'hFF, 1'b0);
    wr(rgt_pkg::OFS_RX_SYNC, 8'h00);
    // Gain overrides
    auto_gain <= 2'h1;
    wr(rgt_pkg::OFS_GAIN_TEST, 8'h0A);
    gchk(2'h1);
    wr(rgt_pkg::OFS_TRX_CTRL0, 8'h20);
    gchk(2'h2);
    wr(rgt_pkg::OFS_GAIN_TEST, 8'h09);
    gchk(2'h1);
    wr(rgt_pkg::OFS_GAIN_TEST, 8'h08);
    gchk(2'h0);
    v = 8'($urandom % 3);
    auto_gain <= v[1:0];
    wr(rgt_pkg::OFS_GAIN_TEST, 8'h02);
    gchk(v[1:0]);
    auto_gain <= 2'h2;
    wr(rgt_pkg::OFS_GAIN_TEST, 8'h10);
    gchk(2'h0);
    wr(rgt_pkg::OFS_GAIN_TEST, 8'h00);
    gchk(2'h2);
    wr(rgt_pkg::OFS_GAIN_TEST, 8'h24);
    auto_gain <= 2'h0;
    repeat (6) @(posedge ref_clk);
    #1 chk("gain_held", 1, gain_held);
    gchk(2'h2);
    wr(rgt_pkg::OFS_GAIN_TEST, 8'h20);
    gchk(2'h0);
    wr(rgt_pkg::OFS_GAIN_TEST, 8'h0A);
    gchk(2'h2);
    wr(rgt_pkg::OFS_GAIN_TEST, 8'h0B);
    gchk(2'h2);
    wr(rgt_pkg::OFS_TRX_CTRL0, 8'h00);
    gchk(2'h0);
    // Transmit start: refused while listening, then pin and command
    sleep_tx_trigger_pin <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk("tx_busy", 0, tx_busy);
    @(posedge ref_clk);
    sleep_tx_trigger_pin <= 1'b0;
    wr(rgt_pkg::OFS_STATE_CTRL, {3'h0, rgt_pkg::CMD_SYNTH_ON});
    sleep_tx_trigger_pin <= 1'b1;
    txrun(rgt_pkg::CMD_SYNTH_ON);
    wr(rgt_pkg::OFS_STATE_CTRL, {3'h0, rgt_pkg::CMD_RETRY_ON});
    rd(rgt_pkg::OFS_STATE_CTRL, {3'h0, rgt_pkg::CMD_RETRY_ON});
    wr(rgt_pkg::OFS_STATE_CTRL, {3'h0, rgt_pkg::CMD_TX_GO});
    txrun(rgt_pkg::CMD_RETRY_ON);
    wr(rgt_pkg::OFS_STATE_CTRL, {3'h0, rgt_pkg::CMD_TRX_OFF});
    rd(rgt_pkg::OFS_STATE_CTRL, {3'h0, rgt_pkg::CMD_TRX_OFF});
    complete_run();
  end
endmodule

bind rgt_rx_gating_gain_tx_start rgt_props u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .reg_re(reg_re), .reg_rdata(reg_rdata), .shr_detect(shr_detect),
  .demod_start(demod_start), .rx_busy(rx_busy), .gain_level(gain_level),
  .gain_held(gain_held), .fb_rd(fb_rd), .tx_chip_strobe(tx_chip_strobe), .tx_busy(tx_busy));

// [verilog/rgt_delay_timer.sv]
// One-shot delay: a start pulse gives a done pulse a fixed number of cycles later.
// Assumes start is a single-cycle pulse; a new start restarts the count.
module rgt_delay_timer #(
  parameter int CYCLES = rgt_pkg::TX_LEAD_CYC
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic start,
  output logic      done_q
);

  logic [11:0] cnt_q;  // Cycles still to wait, zero when idle

  // Count down and pulse on the last cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_q  <= 12'h000;
      done_q <= 1'b0;
    end else begin
      done_q <= (cnt_q == 12'h001);
      if (start) begin
        cnt_q <= 12'(CYCLES - 1);
      end else if (cnt_q != 12'h000) begin
        cnt_q <= cnt_q - 12'h001;
      end
    end
  end

endmodule

// [verilog/rgt_gain_ctrl.sv]
// Receiver gain selection from the test overrides and the automatic loop proposal.
// Assumes the override inputs are already masked by the phase-measure enable.
module rgt_gain_ctrl (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       manual_sel,
  input  wire logic       reset_max,
  input  wire logic       auto_off,
  input  wire logic       freeze,
  input  wire logic [1:0] setting,
  input  wire logic [1:0] auto_gain,
  output logic      [1:0] gain_q,
  output logic            held_q
);

  // Priority: forced maximum, then manual setting, then freeze, then loop
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      gain_q <= rgt_pkg::GAIN_MAX;
      held_q <= 1'b0;
    end else begin
      held_q <= 1'b0;
      if (reset_max) begin
        gain_q <= rgt_pkg::GAIN_MAX;
      end else if (auto_off) begin
        // Reserved code keeps the present gain rather than guessing
        if (setting != rgt_pkg::GAIN_RSV) begin
          gain_q <= setting;
        end
      end else if (manual_sel && freeze) begin
        held_q <= 1'b1;
      end else begin
        gain_q <= auto_gain;
      end
    end
  end

endmodule

// [verilog/rgt_pkg.sv]
// Constants, types and register map of the receive gating, gain and transmit-start block.
// Assumes one 125 MHz clock, a synchronous active-high reset and an 8-bit register port.
package rgt_pkg;

  // Register offsets
  localparam logic [5:0] OFS_STATE_CTRL = 6'h02;
  localparam logic [5:0] OFS_TRX_CTRL0  = 6'h03;
  localparam logic [5:0] OFS_RX_SYNC    = 6'h15;
  localparam logic [5:0] OFS_GAIN_TEST  = 6'h3C;

  // Field positions
  localparam int RXS_BLOCK_BIT   = 7;
  localparam int GT_MANUAL_BIT   = 5;
  localparam int GT_RESET_BIT    = 4;
  localparam int GT_AUTO_OFF_BIT = 3;
  localparam int GT_FREEZE_BIT   = 2;
  localparam int TC0_PHASE_BIT   = 5;

  // Values after reset and writable-bit masks
  localparam logic [7:0] RXS_RST  = 8'h00;
  localparam logic [7:0] GT_RST   = 8'h00;
  localparam logic [7:0] TC0_RST  = 8'h00;
  localparam logic [7:0] RXS_MASK = 8'h8F;
  localparam logic [7:0] GT_MASK  = 8'h3F;
  localparam logic [7:0] TC0_MASK = 8'h20;

  // State commands
  localparam logic [4:0] CMD_TX_GO    = 5'h02;
  localparam logic [4:0] CMD_RX_ON    = 5'h06;
  localparam logic [4:0] CMD_TRX_OFF  = 5'h08;
  localparam logic [4:0] CMD_SYNTH_ON = 5'h09;
  localparam logic [4:0] CMD_RETRY_ON = 5'h19;

  // State codes read back from the state register
  localparam logic [4:0] CODE_RX_BUSY = 5'h01;
  localparam logic [4:0] CODE_TX_BUSY = 5'h02;

  // Gain codes
  localparam logic [1:0] GAIN_MAX = 2'h0;
  localparam logic [1:0] GAIN_RSV = 2'h3;

  // Timing
  localparam int CLK_NS      = 8;
  localparam int TX_LEAD_NS  = 16000;
  localparam int TX_LEAD_CYC = (TX_LEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CHIP_NS     = 500;
  localparam int CHIP_CYC    = CHIP_NS / CLK_NS;

  // Frame layout and spreading
  localparam logic [7:0]  PHR_IDX     = 8'h05;
  localparam logic [7:0]  SFD_IDX     = 8'h04;
  localparam logic [7:0]  SFD_BYTE    = 8'hA7;
  localparam logic [31:0] CHIP_SEQ0   = 32'h744AC39B;
  localparam logic [31:0] ODD_CHIPS   = 32'hAAAAAAAA;
  localparam logic [4:0]  THR_STEP_DB = 5'h03;

  typedef enum logic [2:0] {
    RGT_OFF, RGT_SYNTH, RGT_RETRY, RGT_RX_LISTEN, RGT_RX_BUSY, RGT_TX_LEAD, RGT_TX_SEND
  } rgt_state_t;

endpackage

// [verilog/rgt_rx_gating_gain_tx_start.sv]
// Top of the receive gating, gain override and transmit-start block.
// Assumes a register master with one-cycle strobes and synchronous inputs on ref_clk.
//
// Decided for this implementation: the strobed register port.
module rgt_rx_gating_gain_tx_start (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  output logic      [7:0] reg_rdata,
  input  wire logic       sleep_tx_trigger_pin,
  input  wire logic       shr_detect,
  input  wire logic [7:0] frame_strength,
  input  wire logic       rx_frame_done,
  input  wire logic [1:0] auto_gain,
  input  wire logic [7:0] fb_data,
  output logic            demod_start,
  output logic            rx_busy,
  output logic      [1:0] gain_level,
  output logic            gain_held,
  output logic      [6:0] fb_addr,
  output logic            fb_rd,
  output logic            tx_chip,
  output logic            tx_chip_strobe,
  output logic            tx_busy
);

  // Threshold in dB above the signal-strength floor for a nonzero level
  function automatic logic [7:0] thr_db(input logic [3:0] lvl);
    logic [7:0] step;
    step   = {4'h0, lvl} - 8'h01;
    thr_db = 8'(step * {3'h0, rgt_pkg::THR_STEP_DB});
  endfunction

  // Chip k of the spreading sequence for one 4-bit symbol
  function automatic logic chip_of(input logic [3:0] sym, input logic [4:0] k);
    logic [63:0] dbl;
    logic [31:0] seq;
    dbl = {rgt_pkg::CHIP_SEQ0, rgt_pkg::CHIP_SEQ0};
    // Symbols 1..7 are the base sequence delayed by four chips per step
    seq = 32'(dbl >> (6'd32 - {1'b0, sym[2:0], 2'b00}));
    // Upper eight symbols invert every odd chip
    if (sym[3]) begin
      seq = seq ^ rgt_pkg::ODD_CHIPS;
    end
    chip_of = seq[k];
  endfunction

  // Register storage
  logic [7:0]  rxs_q;      // Receiver sync control
  logic [7:0]  gt_q;       // Gain control test
  logic [7:0]  tc0_q;      // Transceiver control zero
  logic [7:0]  rd_val;     // Read mux output

  // State machine
  rgt_pkg::rgt_state_t st_q;
  rgt_pkg::rgt_state_t ret_q;  // Where a finished transmission returns to

  // Trigger pin history for edge detection
  logic        pin_q;
  logic        pin_rise;

  // Decoded strobes
  logic        cmd_wr;
  logic [4:0]  cmd;
  logic        tx_go;
  logic        accept;
  logic        lead_done;
  logic        send_last;

  // Chip engine
  logic [7:0]  byte_idx_q;   // Byte of the over-air frame being sent
  logic [7:0]  cur_byte_q;   // Byte being spread
  logic [7:0]  next_byte_q;  // Prefetched following byte
  logic [5:0]  chip_idx_q;   // Chip within the byte, two symbols of 32
  logic [5:0]  chip_tmr_q;   // Cycles within one chip
  logic [6:0]  frame_len_q;  // Payload length taken from the header byte
  logic        fetch_q;      // Frame buffer data arrives this cycle
  logic [7:0]  fetch_idx_q;  // Frame byte index of that data
  logic        chip_tick;
  logic [7:0]  nxt_idx;
  logic [7:0]  nxt_ofs;
  logic [7:0]  last_idx;
  logic [3:0]  nibble;

  // Effective gain overrides
  logic [7:0]  gt_eff;

  assign cmd_wr    = reg_we && (reg_addr == rgt_pkg::OFS_STATE_CTRL);
  assign cmd       = reg_wdata[4:0];
  assign pin_rise  = sleep_tx_trigger_pin && !pin_q;
  assign chip_tick = (chip_tmr_q == 6'(rgt_pkg::CHIP_CYC - 1));
  assign nxt_idx   = byte_idx_q + 8'h01;
  assign nxt_ofs   = nxt_idx - rgt_pkg::PHR_IDX;
  assign last_idx  = rgt_pkg::PHR_IDX + {1'b0, frame_len_q};
  assign nibble    = chip_idx_q[5] ? cur_byte_q[7:4] : cur_byte_q[3:0];

  // Only synth-ready and auto-retry states may launch a frame
  assign tx_go = (pin_rise || (cmd_wr && (cmd == rgt_pkg::CMD_TX_GO)))
               && ((st_q == rgt_pkg::RGT_SYNTH) || (st_q == rgt_pkg::RGT_RETRY));

  // Frame start is taken only while listening, never while already busy,
  // so setting the block bit mid-frame leaves that frame untouched
  assign accept = (st_q == rgt_pkg::RGT_RX_LISTEN) && shr_detect
                && !rxs_q[rgt_pkg::RXS_BLOCK_BIT]
                && ((rxs_q[3:0] == 4'h0)
                    || (frame_strength > thr_db(rxs_q[3:0])));

  // Last chip of the last byte closes the frame
  assign send_last = (st_q == rgt_pkg::RGT_TX_SEND) && chip_tick
                   && (chip_idx_q == 6'h3F) && (byte_idx_q == last_idx);

  // Overrides apply only with phase measurement on; fields stay accessible
  assign gt_eff = tc0_q[rgt_pkg::TC0_PHASE_BIT] ? gt_q : rgt_pkg::GT_RST;

  // Register writes; reserved bits are never stored
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rxs_q <= rgt_pkg::RXS_RST;
      gt_q  <= rgt_pkg::GT_RST;
      tc0_q <= rgt_pkg::TC0_RST;
    end else if (reg_we) begin
      if (reg_addr == rgt_pkg::OFS_RX_SYNC) begin
        rxs_q <= reg_wdata & rgt_pkg::RXS_MASK;
      end else if (reg_addr == rgt_pkg::OFS_GAIN_TEST) begin
        gt_q <= reg_wdata & rgt_pkg::GT_MASK;
      end else if (reg_addr == rgt_pkg::OFS_TRX_CTRL0) begin
        tc0_q <= reg_wdata & rgt_pkg::TC0_MASK;
      end
    end
  end

  // Read mux; the state register shows the block's own state
  always_comb begin
    rd_val = 8'h00;
    if (reg_addr == rgt_pkg::OFS_STATE_CTRL) begin
      case (st_q)
        rgt_pkg::RGT_SYNTH:     rd_val = {3'h0, rgt_pkg::CMD_SYNTH_ON};
        rgt_pkg::RGT_RETRY:     rd_val = {3'h0, rgt_pkg::CMD_RETRY_ON};
        rgt_pkg::RGT_RX_LISTEN: rd_val = {3'h0, rgt_pkg::CMD_RX_ON};
        rgt_pkg::RGT_RX_BUSY:   rd_val = {3'h0, rgt_pkg::CODE_RX_BUSY};
        rgt_pkg::RGT_TX_LEAD:   rd_val = {3'h0, rgt_pkg::CODE_TX_BUSY};
        rgt_pkg::RGT_TX_SEND:   rd_val = {3'h0, rgt_pkg::CODE_TX_BUSY};
        default:                rd_val = {3'h0, rgt_pkg::CMD_TRX_OFF};
      endcase
    end else if (reg_addr == rgt_pkg::OFS_TRX_CTRL0) begin
      rd_val = tc0_q;
    end else if (reg_addr == rgt_pkg::OFS_RX_SYNC) begin
      rd_val = rxs_q;
    end else if (reg_addr == rgt_pkg::OFS_GAIN_TEST) begin
      rd_val = gt_q;
    end
  end

  // Read data stand for exactly one cycle, zero otherwise
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_re ? rd_val : 8'h00;
    end
  end

  // Trigger pin history
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= sleep_tx_trigger_pin;
    end
  end

  // Transceiver state machine; off command wins in every state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q  <= rgt_pkg::RGT_OFF;
      ret_q <= rgt_pkg::RGT_SYNTH;
    end else if (cmd_wr && (cmd == rgt_pkg::CMD_TRX_OFF)) begin
      st_q <= rgt_pkg::RGT_OFF;
    end else begin
      case (st_q)
        rgt_pkg::RGT_OFF: begin
          if (cmd_wr && (cmd == rgt_pkg::CMD_RX_ON)) begin
            st_q <= rgt_pkg::RGT_RX_LISTEN;
          end else if (cmd_wr && (cmd == rgt_pkg::CMD_SYNTH_ON)) begin
            st_q <= rgt_pkg::RGT_SYNTH;
          end else if (cmd_wr && (cmd == rgt_pkg::CMD_RETRY_ON)) begin
            st_q <= rgt_pkg::RGT_RETRY;
          end
        end
        rgt_pkg::RGT_SYNTH: begin
          if (tx_go) begin
            st_q  <= rgt_pkg::RGT_TX_LEAD;
            ret_q <= rgt_pkg::RGT_SYNTH;
          end else if (cmd_wr && (cmd == rgt_pkg::CMD_RX_ON)) begin
            st_q <= rgt_pkg::RGT_RX_LISTEN;
          end else if (cmd_wr && (cmd == rgt_pkg::CMD_RETRY_ON)) begin
            st_q <= rgt_pkg::RGT_RETRY;
          end
        end
        rgt_pkg::RGT_RETRY: begin
          if (tx_go) begin
            st_q  <= rgt_pkg::RGT_TX_LEAD;
            ret_q <= rgt_pkg::RGT_RETRY;
          end else if (cmd_wr && (cmd == rgt_pkg::CMD_SYNTH_ON)) begin
            st_q <= rgt_pkg::RGT_SYNTH;
          end
        end
        rgt_pkg::RGT_RX_LISTEN: begin
          // Blocked receiver simply stays here; only a synth-on or off command moves it on
          if (accept) begin
            st_q <= rgt_pkg::RGT_RX_BUSY;
          end else if (cmd_wr && (cmd == rgt_pkg::CMD_SYNTH_ON)) begin
            st_q <= rgt_pkg::RGT_SYNTH;
          end
        end
        rgt_pkg::RGT_RX_BUSY: begin
          // Runs to the end of frame whatever the block bit does
          if (rx_frame_done) begin
            st_q <= rgt_pkg::RGT_RX_LISTEN;
          end
        end
        rgt_pkg::RGT_TX_LEAD: begin
          if (lead_done) begin
            st_q <= rgt_pkg::RGT_TX_SEND;
          end
        end
        rgt_pkg::RGT_TX_SEND: begin
          if (send_last) begin
            st_q <= ret_q;
          end
        end
        default: st_q <= rgt_pkg::RGT_OFF;
      endcase
    end
  end

  // Fixed lead time between the trigger and the first chip
  rgt_delay_timer #(
    .CYCLES (rgt_pkg::TX_LEAD_CYC)
  ) u_lead (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .start   (tx_go),
    .done_q  (lead_done)
  );

  // Status outputs
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      demod_start <= 1'b0;
      rx_busy     <= 1'b0;
      tx_busy     <= 1'b0;
    end else begin
      demod_start <= accept;
      rx_busy     <= (st_q == rgt_pkg::RGT_RX_BUSY);
      tx_busy     <= (st_q == rgt_pkg::RGT_TX_LEAD) || (st_q == rgt_pkg::RGT_TX_SEND);
    end
  end

  // Chip timing and byte sequencing. The chip period is rounded down to
  // whole cycles, so the chip rate runs slightly fast of nominal.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      chip_tmr_q     <= 6'h00;
      chip_idx_q     <= 6'h00;
      byte_idx_q     <= 8'h00;
      cur_byte_q     <= 8'h00;
      tx_chip        <= 1'b0;
      tx_chip_strobe <= 1'b0;
    end else if (st_q != rgt_pkg::RGT_TX_SEND) begin
      // Preamble byte is zero; state is ready for the first chip
      chip_tmr_q     <= 6'h00;
      chip_idx_q     <= 6'h00;
      byte_idx_q     <= 8'h00;
      cur_byte_q     <= 8'h00;
      tx_chip_strobe <= 1'b0;
    end else begin
      tx_chip_strobe <= chip_tick;
      if (chip_tick) begin
        chip_tmr_q <= 6'h00;
        tx_chip    <= chip_of(nibble, chip_idx_q[4:0]);
        chip_idx_q <= chip_idx_q + 6'h01;
        if (chip_idx_q == 6'h3F) begin
          byte_idx_q <= nxt_idx;
          cur_byte_q <= next_byte_q;
        end
      end else begin
        chip_tmr_q <= chip_tmr_q + 6'h01;
      end
    end
  end

  // Prefetch of the following byte at the first chip of each byte.
  // Preamble and SFD bytes come from constants; the header byte and the rest from the frame buffer.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fb_addr     <= 7'h00;
      fb_rd       <= 1'b0;
      fetch_q     <= 1'b0;
      fetch_idx_q <= 8'h00;
      next_byte_q <= 8'h00;
      frame_len_q <= 7'h00;
    end else begin
      fb_rd   <= 1'b0;
      fetch_q <= fb_rd;
      if ((st_q == rgt_pkg::RGT_TX_SEND) && chip_tick && (chip_idx_q == 6'h00)) begin
        fetch_idx_q <= nxt_idx;
        if (nxt_idx < rgt_pkg::SFD_IDX) begin
          next_byte_q <= 8'h00;
        end else if (nxt_idx == rgt_pkg::SFD_IDX) begin
          next_byte_q <= rgt_pkg::SFD_BYTE;
        end else if (nxt_idx <= last_idx) begin  // Never fetch past the last payload byte
          fb_addr <= nxt_ofs[6:0];
          fb_rd   <= 1'b1;
        end
      end
      if (fetch_q) begin
        next_byte_q <= fb_data;
        if (fetch_idx_q == rgt_pkg::PHR_IDX) begin
          frame_len_q <= fb_data[6:0];
        end
      end
    end
  end

  // Gain selection behind the phase-measure gate
  rgt_gain_ctrl u_gain (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .manual_sel (gt_eff[rgt_pkg::GT_MANUAL_BIT]),
    .reset_max  (gt_eff[rgt_pkg::GT_RESET_BIT]),
    .auto_off   (gt_eff[rgt_pkg::GT_AUTO_OFF_BIT]),
    .freeze     (gt_eff[rgt_pkg::GT_FREEZE_BIT]),
    .setting    (gt_eff[1:0]),
    .auto_gain  (auto_gain),
    .gain_q     (gain_level),
    .held_q     (gain_held)
  );

endmodule
